/* hw/ims_ctrl.sv */
// two-wire bus controller: master sequencer, slave address match, register file
// assumes open-drain pads outside (oe high pulls low) and an Avalon-MM master
//
// Function
// - scl period is reload plus one plus five
// - mask bits make address bits don't-care
// - mask applies only without accept-all mode
// - reserved addresses other than general call never match nor acknowledge
// - general call acked only with accept bit
// - 11110xx matches only as ten-bit upper byte
// - module_on enables controller and claims pins
// - idle_halt freezes controller during chip idle
// - clock_release low holds scl low while the slave state machine is not idle
// - hardware clears release at tx start, rx end
// - without stretch, software may only set release
// - accept-all mode acknowledges every address except reserved ones and 11110xx in seven-bit mode
// - ten_bit_select picks ten or seven bit compare
// - accepted general call raises a status flag
// - stretch_allow gates software and receive stretching
// - master runs start, bytes, restart, acks, stop
// - reload covers 100 kHz and 400 kHz
// - start, restart, stop bits cleared when done
// - receive_go cleared after eighth received bit
// - ack_go sends ack_value, then clears
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module ims_ctrl (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// avalon-mm slave
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output var  logic [31:0] o_avs_readdata,
	output var  logic        o_avs_waitrequest,
	// chip power state
	input  wire logic        i_cpu_idle,
	// bus pins
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output var  logic        o_scl_o,
	output var  logic        o_scl_oe,
	output var  logic        o_sda_o,
	output var  logic        o_sda_oe,
	output var  logic        o_pins_owned
);

	////////////////////////////////////////////////////////////////////////
	ims_pkg::ims_ctrl_t   ctl_r, ctl_nxt, ctl_w;
	ims_pkg::ims_stat_t   stat;
	ims_pkg::ims_mstate_t m_state;
	ims_pkg::ims_sstate_t s_state, s_dec_state;
	logic [15:0] rate_r;
	logic [9:0]  mask_r, own_r;
	logic [7:0]  rx_r, m_tx_sr, m_rx_sr, s_sr, s_tx_sr;
	logic [1:0]  meta_r, pin_r, pin_d_r, m_ph;
	logic [16:0] m_period, m_half, tm_r;
	logic [3:0]  m_bit, s_cnt;
	logic        wreq_r, take, wr, rd, run, scl_in, sda_in;
	logic        scl_rise, scl_fall, bus_start, bus_stop;
	logic        m_want_scl, m_want_sda, m_last, m_bitv, m_run_tm, m_adv, m_done, m_bittype, m_collide;
	logic        m_scl_low_r, m_sda_low_r, m_owner_r, nack_r, coll_r, rx_full_r, drive_lvl_r;
	logic        s_ackph_r, s_ack_r, s_mnack_r, s_sel_r, s_ten_r, s_gc_r, s_rw_r, s_data_r;
	logic        s_dec_ack, s_dec_gc, s_rsvd, s_m7, s_mhi, s_m8, s_scl_low, s_rel_clr, s_rx_done;

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait state, answer on the second edge
	assign take = (i_avs_read | i_avs_write) & ~wreq_r;
	assign wr   = i_avs_write & take;
	assign rd   = i_avs_read & take;
	assign ctl_w = ims_pkg::ims_ctrl_t'(i_avs_writedata[15:0] & ims_pkg::CTRL_WMASK);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			wreq_r <= 1'b1;
		else
			wreq_r <= ~((i_avs_read | i_avs_write) & wreq_r);
	end
	assign o_avs_waitrequest = wreq_r;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			o_avs_readdata <= 32'h0;
		else if (i_avs_read && wreq_r) begin
			case (i_avs_address)
				ims_pkg::OFS_CTRL: o_avs_readdata <= 32'(ctl_r);
				ims_pkg::OFS_RATE: o_avs_readdata <= 32'(rate_r);
				ims_pkg::OFS_MASK: o_avs_readdata <= 32'(mask_r);
				ims_pkg::OFS_ADDR: o_avs_readdata <= 32'(own_r);
				ims_pkg::OFS_RXD:  o_avs_readdata <= 32'(rx_r);
				ims_pkg::OFS_STAT: o_avs_readdata <= 32'(stat);
				default:           o_avs_readdata <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rate_r <= ims_pkg::RATE_STD;
			mask_r <= 10'h000;
			own_r  <= 10'h000;
		end else if (wr) begin
			if (i_avs_address == ims_pkg::OFS_RATE)
				rate_r <= i_avs_writedata[15:0];
			if (i_avs_address == ims_pkg::OFS_MASK)
				mask_r <= i_avs_writedata[9:0];
			if (i_avs_address == ims_pkg::OFS_ADDR)
				own_r <= i_avs_writedata[9:0];
		end
	end

	always_comb begin
		ctl_nxt = ctl_r;
		if (m_done) begin
			case (m_state)
				ims_pkg::M_START:   ctl_nxt.start_go = 1'b0;
				ims_pkg::M_RESTART: ctl_nxt.restart_go = 1'b0;
				ims_pkg::M_STOP:    ctl_nxt.stop_go = 1'b0;
				ims_pkg::M_RX:      ctl_nxt.receive_go = 1'b0;
				ims_pkg::M_ACK:     ctl_nxt.ack_go = 1'b0;
				default:            ctl_nxt.start_go = ctl_r.start_go;
			endcase
		end
		if (m_collide)
			ctl_nxt[4:0] = 5'h00;
		if (s_rel_clr)
			ctl_nxt.clock_release = 1'b0;
		if (wr && i_avs_address == ims_pkg::OFS_CTRL) begin
			ctl_nxt = ctl_w;
			ctl_nxt.clock_release = ctl_r.stretch_allow ? ctl_w.clock_release
				: (ctl_w.clock_release | (ctl_r.clock_release & ~s_rel_clr));
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			ctl_r <= ims_pkg::ims_ctrl_t'(ims_pkg::CTRL_RST);
		else
			ctl_r <= ctl_nxt;
	end

	assign stat = '{bus_owner: m_owner_r, ten_matched: s_ten_r, slave_read: s_rw_r,
		slave_selected: s_sel_r, gc_seen: s_gc_r, rx_full: rx_full_r, collided: coll_r,
		nack_seen: nack_r, master_busy: (m_state != ims_pkg::M_IDLE)};

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and bus conditions
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_r  <= 2'h3;
			pin_r   <= 2'h3;
			pin_d_r <= 2'h3;
		end else begin
			meta_r  <= {i_scl, i_sda};
			pin_r   <= meta_r;
			pin_d_r <= pin_r;
		end
	end
	assign scl_in = pin_r[1];
	assign sda_in = pin_r[0];
	assign run       = ctl_r.module_on & ~(ctl_r.idle_halt & i_cpu_idle);
	assign scl_rise  = run & scl_in & ~pin_d_r[1];
	assign scl_fall  = run & ~scl_in & pin_d_r[1];
	assign bus_start = run & scl_in & pin_d_r[1] & ~sda_in & pin_d_r[0];
	assign bus_stop  = run & scl_in & pin_d_r[1] & sda_in & ~pin_d_r[0];

	////////////////////////////////////////////////////////////////////////
	// master sequencer: each phase lasts half a period
	// period from reload
	assign m_period = 17'(rate_r) + 17'h1 + ims_pkg::BRG_FIX;
	assign m_half   = m_period >> 1;
	assign m_bittype = (m_state == ims_pkg::M_TX) | (m_state == ims_pkg::M_RX) | (m_state == ims_pkg::M_ACK);

	always_comb begin
		m_bitv = 1'b1;
		if (m_state == ims_pkg::M_TX && m_bit < ims_pkg::BYTE_BITS)
			m_bitv = m_tx_sr[7];
		if (m_state == ims_pkg::M_ACK)
			m_bitv = ctl_r.ack_value;
		case (m_state)
			ims_pkg::M_START: begin
				m_want_scl = (m_ph == 2'h2);
				m_want_sda = (m_ph != 2'h0);
				m_last     = (m_ph == 2'h2);
			end
			ims_pkg::M_RESTART: begin
				m_want_scl = (m_ph == 2'h0) || (m_ph == 2'h3);
				m_want_sda = (m_ph >= 2'h2);
				m_last     = (m_ph == 2'h3);
			end
			ims_pkg::M_STOP: begin
				m_want_scl = (m_ph == 2'h0);
				m_want_sda = (m_ph != 2'h2);
				m_last     = (m_ph == 2'h2);
			end
			ims_pkg::M_TX, ims_pkg::M_RX, ims_pkg::M_ACK: begin
				m_want_scl = (m_ph == 2'h0);
				m_want_sda = ~m_bitv;
				m_last     = (m_ph == 2'h1);
			end
			default: begin
				m_want_scl = 1'b0;
				m_want_sda = 1'b0;
				m_last     = 1'b1;
			end
		endcase
	end

	// released phases wait for scl to read high, so slaves may stretch
	assign m_run_tm = run & (m_state != ims_pkg::M_IDLE) & (m_want_scl | scl_in);
	assign m_adv    = m_run_tm & (tm_r == m_half - 17'h1);
	assign m_done   = m_adv & m_last & ((m_state == ims_pkg::M_TX) ? (m_bit == ims_pkg::BYTE_BITS)
		: (m_state == ims_pkg::M_RX) ? (m_bit == ims_pkg::BYTE_BITS - 4'h1) : 1'b1);
	assign m_collide = run & (m_state == ims_pkg::M_TX) & (m_bit < ims_pkg::BYTE_BITS)
		& (m_ph == 2'h1) & ~m_want_sda & scl_in & ~sda_in;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !ctl_r.module_on || m_collide) begin
			m_state <= ims_pkg::M_IDLE;
			tm_r    <= 17'h0;
			m_ph    <= 2'h0;
			m_bit   <= 4'h0;
		end else if (m_state == ims_pkg::M_IDLE) begin
			tm_r  <= 17'h0;
			m_ph  <= 2'h0;
			m_bit <= 4'h0;
			if (run) begin
				if (ctl_r.start_go)
					m_state <= ims_pkg::M_START;
				else if (ctl_r.restart_go)
					m_state <= ims_pkg::M_RESTART;
				else if (ctl_r.stop_go)
					m_state <= ims_pkg::M_STOP;
				else if (ctl_r.receive_go)
					m_state <= ims_pkg::M_RX;
				else if (ctl_r.ack_go)
					m_state <= ims_pkg::M_ACK;
				else if (wr && i_avs_address == ims_pkg::OFS_TXD && m_owner_r)
					m_state <= ims_pkg::M_TX;
			end
		end else if (m_adv) begin
			tm_r <= 17'h0;
			if (!m_last)
				m_ph <= m_ph + 2'h1;
			else begin
				m_ph <= 2'h0;
				if (m_done)
					m_state <= ims_pkg::M_IDLE;
				else
					m_bit <= m_bit + 4'h1;
			end
		end else if (m_run_tm)
			tm_r <= tm_r + 17'h1;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !ctl_r.module_on || m_collide) begin
			m_scl_low_r <= 1'b0;
			m_sda_low_r <= 1'b0;
			m_owner_r   <= 1'b0;
		end else if (m_state != ims_pkg::M_IDLE) begin
			// after a byte or ack the master parks scl low
			m_scl_low_r <= (m_done && m_bittype) ? 1'b1 : m_want_scl;
			m_sda_low_r <= (m_done && m_bittype) ? 1'b0 : m_want_sda;
			if (m_done && (m_state == ims_pkg::M_START || m_state == ims_pkg::M_RESTART))
				m_owner_r <= 1'b1;
			if (m_done && m_state == ims_pkg::M_STOP)
				m_owner_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			m_tx_sr <= 8'h00;
			m_rx_sr <= 8'h00;
			nack_r  <= 1'b0;
		end else begin
			if (m_state == ims_pkg::M_IDLE && wr && i_avs_address == ims_pkg::OFS_TXD)
				m_tx_sr <= i_avs_writedata[7:0];
			else if (m_adv && m_last && m_state == ims_pkg::M_TX)
				m_tx_sr <= {m_tx_sr[6:0], 1'b0};
			if (m_adv && m_last && m_state == ims_pkg::M_RX)
				m_rx_sr <= {m_rx_sr[6:0], sda_in};
			if (m_done && m_state == ims_pkg::M_TX)
				nack_r <= sda_in;
		end
	end

	// collision flag: write one clears, a new collision wins
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			coll_r <= 1'b0;
		else if (m_collide)
			coll_r <= 1'b1;
		else if (wr && i_avs_address == ims_pkg::OFS_STAT && i_avs_writedata[2])
			coll_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// slave address decode
	// masked compares
	assign s_m7  = &(~(s_sr[7:1] ^ own_r[6:0]) | mask_r[6:0]);
	assign s_mhi = &(~(s_sr[2:1] ^ own_r[9:8]) | mask_r[9:8]);
	assign s_m8  = &(~(s_sr ^ own_r[7:0]) | mask_r[7:0]);
	assign s_rsvd = (s_sr[7:4] == ims_pkg::RSV_LOW4) || (s_sr[7:3] == ims_pkg::RSV_HI5);

	always_comb begin
		s_dec_ack   = 1'b0;
		s_dec_gc    = 1'b0;
		s_dec_state = ims_pkg::S_IDLE;
		case (s_state)
			ims_pkg::S_ADDR: begin
				if (s_sr == ims_pkg::GC_BYTE) begin
					s_dec_ack   = ctl_r.general_call_accept;
					s_dec_gc    = ctl_r.general_call_accept;
					s_dec_state = ctl_r.general_call_accept ? ims_pkg::S_RXD : ims_pkg::S_IDLE;
				end else if (s_sr[7:3] == ims_pkg::TEN_HI5) begin
					if (ctl_r.ten_bit_select && (ctl_r.accept_all_addr || s_mhi) && (!s_sr[0] || s_ten_r)) begin
						s_dec_ack   = 1'b1;
						s_dec_state = s_sr[0] ? ims_pkg::S_TXD : ims_pkg::S_ADDR2;
					end
				end else if (!s_rsvd && !ctl_r.ten_bit_select && (ctl_r.accept_all_addr || s_m7)) begin
					s_dec_ack   = 1'b1;
					s_dec_state = s_sr[0] ? ims_pkg::S_TXD : ims_pkg::S_RXD;
				end
			end
			ims_pkg::S_ADDR2: begin
				if (ctl_r.accept_all_addr || s_m8) begin
					s_dec_ack   = 1'b1;
					s_dec_state = ims_pkg::S_RXD;
				end
			end
			ims_pkg::S_RXD: begin
				s_dec_ack   = 1'b1;
				s_dec_state = ims_pkg::S_RXD;
			end
			ims_pkg::S_TXD: s_dec_state = ims_pkg::S_TXD;
			default: s_dec_state = ims_pkg::S_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// slave bit engine: bits counted on rise, ack handled on falls
	assign s_rx_done = scl_fall & ~s_ackph_r & (s_cnt == ims_pkg::BYTE_BITS) & (s_state == ims_pkg::S_RXD);
	// clear at tx start and data rx end
	assign s_rel_clr = scl_fall & s_ackph_r & (((s_state == ims_pkg::S_TXD) & ~s_mnack_r)
		| ((s_state == ims_pkg::S_RXD) & s_data_r & ctl_r.stretch_allow));
	assign s_scl_low = (s_state != ims_pkg::S_IDLE) & ~ctl_r.clock_release;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !ctl_r.module_on || bus_stop) begin
			s_state   <= ims_pkg::S_IDLE;
			s_cnt     <= 4'h0;
			s_ackph_r <= 1'b0;
			s_ack_r   <= 1'b0;
			s_mnack_r <= 1'b0;
			s_sel_r   <= 1'b0;
			s_ten_r   <= 1'b0;
			s_gc_r    <= 1'b0;
			s_rw_r    <= 1'b0;
			s_data_r  <= 1'b0;
			s_sr      <= 8'h00;
		end else if (bus_start) begin
			s_state   <= ims_pkg::S_ADDR;
			s_cnt     <= 4'h0;
			s_ackph_r <= 1'b0;
			s_ack_r   <= 1'b0;
		end else if (scl_rise && s_state != ims_pkg::S_IDLE) begin
			if (s_ackph_r)
				s_mnack_r <= sda_in;
			else if (s_cnt < ims_pkg::BYTE_BITS) begin
				s_sr  <= {s_sr[6:0], sda_in};
				s_cnt <= s_cnt + 4'h1;
			end
		end else if (scl_fall && s_state != ims_pkg::S_IDLE) begin
			if (!s_ackph_r && s_cnt == ims_pkg::BYTE_BITS) begin
				s_ackph_r <= 1'b1;
				s_ack_r   <= s_dec_ack;
				s_state   <= s_dec_state;
				s_mnack_r <= 1'b0;
				s_data_r  <= (s_state == ims_pkg::S_RXD);
				s_sel_r   <= s_sel_r | s_dec_ack;
				s_gc_r    <= s_gc_r | s_dec_gc;
				if (s_state == ims_pkg::S_ADDR && s_dec_ack)
					s_rw_r <= s_sr[0];
				if (s_state == ims_pkg::S_ADDR2 && s_dec_ack)
					s_ten_r <= 1'b1;
			end else if (s_ackph_r) begin
				s_ackph_r <= 1'b0;
				s_ack_r   <= 1'b0;
				s_cnt     <= 4'h0;
				if (s_state == ims_pkg::S_TXD && s_mnack_r)
					s_state <= ims_pkg::S_IDLE;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			s_tx_sr <= 8'h00;
		else if (wr && i_avs_address == ims_pkg::OFS_TXD && !m_owner_r)
			s_tx_sr <= i_avs_writedata[7:0];
		else if (scl_fall && s_state == ims_pkg::S_TXD && !s_ackph_r && s_cnt != 4'h0 && s_cnt < ims_pkg::BYTE_BITS)
			s_tx_sr <= {s_tx_sr[6:0], 1'b1};
	end

	// received byte: a new byte wins over the read that empties it
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rx_r      <= 8'h00;
			rx_full_r <= 1'b0;
		end else begin
			if (rd && i_avs_address == ims_pkg::OFS_RXD)
				rx_full_r <= 1'b0;
			if (m_done && m_state == ims_pkg::M_RX) begin
				rx_r      <= {m_rx_sr[6:0], sda_in};
				rx_full_r <= 1'b1;
			end else if (s_rx_done) begin
				rx_r      <= s_sr;
				rx_full_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pads
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_scl_oe     <= 1'b0;
			o_sda_oe     <= 1'b0;
			o_pins_owned <= 1'b0;
			drive_lvl_r  <= 1'b0;
		end else begin
			o_pins_owned <= ctl_r.module_on;
			o_scl_oe     <= ctl_r.module_on & (m_scl_low_r | s_scl_low);
			o_sda_oe     <= ctl_r.module_on & (m_sda_low_r | s_ack_r
				| ((s_state == ims_pkg::S_TXD) & ~s_ackph_r & (s_cnt < ims_pkg::BYTE_BITS) & ~s_tx_sr[7]));
			drive_lvl_r  <= 1'b0;
		end
	end
	assign o_scl_o = drive_lvl_r;
	assign o_sda_o = drive_lvl_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence start_end_s;
		m_state == ims_pkg::M_START && m_adv && m_ph == 2'h2;
	endsequence
	sequence start_after_s;
		!ctl_r.start_go && m_state == ims_pkg::M_IDLE ##1 o_scl_oe && o_sda_oe;
	endsequence

	pins_off_a: assert property (!ctl_r.module_on |=> !o_pins_owned && !o_scl_oe && !o_sda_oe)
		else $error("pins driven while module off");
	halt_hold_a: assert property (ctl_r.idle_halt && i_cpu_idle |=> $stable(m_state) && $stable(tm_r))
		else $error("controller ran during idle halt");
	stretch_hold_a: assert property (s_scl_low && ctl_r.module_on |=> o_scl_oe)
		else $error("scl not held while release low");
	rel_setonly_a: assert property (wr && i_avs_address == ims_pkg::OFS_CTRL && !ctl_r.stretch_allow
		&& ctl_r.clock_release && !s_rel_clr |=> ctl_r.clock_release)
		else $error("release cleared by software without stretch");
	gc_gate_a: assert property (scl_fall && !s_ackph_r && s_cnt == ims_pkg::BYTE_BITS && s_state == ims_pkg::S_ADDR
		&& s_sr == ims_pkg::GC_BYTE |=> s_ack_r == ctl_r.general_call_accept)
		else $error("general call ack does not follow accept bit");
	rsvd_nak_a: assert property (scl_fall && !s_ackph_r && s_cnt == ims_pkg::BYTE_BITS && s_state == ims_pkg::S_ADDR
		&& s_rsvd && s_sr != ims_pkg::GC_BYTE |=> !s_ack_r)
		else $error("reserved address acknowledged");
	start_clr_a: assert property (start_end_s |=> start_after_s)
		else $error("start request not completed");
	rx_clr_a: assert property (m_state == ims_pkg::M_RX && m_done |=> !ctl_r.receive_go && rx_full_r)
		else $error("receive request not cleared after byte");
	coll_quit_a: assert property (m_collide |=> m_state == ims_pkg::M_IDLE && coll_r && !m_owner_r
		##1 !o_sda_oe || s_ack_r)
		else $error("master kept driving after lost arbitration");
	phase_len_a: assert property (m_state == ims_pkg::M_TX && m_ph == 2'h0 && tm_r == 17'h0 && m_run_tm
		&& rate_r == ims_pkg::RATE_FAST |-> ##61 m_adv)
		else $error("low phase length wrong");

endmodule

`default_nettype wire

/* hw/ims_pkg.sv */
// constants, field layouts and state codes of the two-wire bus controller
// assumes a 50 MHz system clock and a word-aligned Avalon-MM register map
`default_nettype none

package ims_pkg;

	localparam int          CLK_HZ      = 50_000_000;
	localparam int          BRG_REF_HZ  = 10_000_000;
	localparam int          SCL_STD_HZ  = 100_000;
	localparam int          SCL_FAST_HZ = 400_000;
	localparam logic [16:0] BRG_FIX     = 17'(CLK_HZ / BRG_REF_HZ);
	localparam logic [15:0] RATE_STD    = 16'(CLK_HZ / SCL_STD_HZ - CLK_HZ / BRG_REF_HZ - 1);
	localparam logic [15:0] RATE_FAST   = 16'(CLK_HZ / SCL_FAST_HZ - CLK_HZ / BRG_REF_HZ - 1);

	localparam logic [4:0]  OFS_CTRL = 5'h00;
	localparam logic [4:0]  OFS_RATE = 5'h04;
	localparam logic [4:0]  OFS_MASK = 5'h08;
	localparam logic [4:0]  OFS_ADDR = 5'h0C;
	localparam logic [4:0]  OFS_TXD  = 5'h10;
	localparam logic [4:0]  OFS_RXD  = 5'h14;
	localparam logic [4:0]  OFS_STAT = 5'h18;

	localparam logic [15:0] CTRL_RST   = 16'h1000;
	localparam logic [15:0] CTRL_WMASK = 16'hBFFF;
	localparam logic [7:0]  GC_BYTE    = 8'h00;
	localparam logic [3:0]  RSV_LOW4   = 4'h0;
	localparam logic [4:0]  RSV_HI5    = 5'h1F;
	localparam logic [4:0]  TEN_HI5    = 5'h1E;
	localparam logic [3:0]  BYTE_BITS  = 4'h8;

	typedef struct packed {
		logic module_on;
		logic unused14;
		logic idle_halt;
		logic clock_release;
		logic accept_all_addr;
		logic ten_bit_select;
		logic slew_off;
		logic smbus_levels;
		logic general_call_accept;
		logic stretch_allow;
		logic ack_value;
		logic ack_go;
		logic receive_go;
		logic stop_go;
		logic restart_go;
		logic start_go;
	} ims_ctrl_t;

	typedef struct packed {
		logic bus_owner;
		logic ten_matched;
		logic slave_read;
		logic slave_selected;
		logic gc_seen;
		logic rx_full;
		logic collided;
		logic nack_seen;
		logic master_busy;
	} ims_stat_t;

	typedef enum logic [6:0] {
		M_IDLE    = 7'h01,
		M_START   = 7'h02,
		M_RESTART = 7'h04,
		M_STOP    = 7'h08,
		M_TX      = 7'h10,
		M_RX      = 7'h20,
		M_ACK     = 7'h40
	} ims_mstate_t;

	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_ADDR  = 5'h02,
		S_ADDR2 = 5'h04,
		S_RXD   = 5'h08,
		S_TXD   = 5'h10
	} ims_sstate_t;

endpackage

`default_nettype wire

/* tb/ims_peer.sv */
// behavioural target on the two-wire bus: acks one address, returns one byte
// assumes the bench resolves both pulled-up wires from every enable
`timescale 1ns/1ns
`default_nettype none
module ims_peer #(
	parameter logic [6:0] ADDR = 7'h50,
	parameter logic [7:0] DATA = 8'hA5
) (
	input  wire logic scl,
	input  wire logic sda,
	output var  logic sda_oe
);
	logic [7:0] sh = 8'h00;
	int         cnt = 0;
	logic       ad = 1'b0;
	logic       sel = 1'b0;
	logic       rd = 1'b0;
	initial sda_oe = 1'b0;
	////////////////////////////////////////////////////////////////
	// start or stop: sda moves while scl is high
	always @(sda) begin
		if (scl === 1'b1) begin
			cnt = 0;
			ad = 1'b0;
			sel = 1'b0;
			sda_oe = 1'b0;
		end
	end
	always @(posedge scl) begin
		sh = {sh[6:0], sda};
		cnt = cnt + 1;
	end
	// address ack, data ack, read byte
	always @(negedge scl) begin
		if (cnt == 9)
			cnt = 0;
		if (cnt == 8 && !ad) begin
			ad = 1'b1;
			sel = (sh[7:1] == ADDR);
			rd = sh[0];
			sda_oe = sel;
		end else if (cnt == 8)
			sda_oe = sel && !rd;
		else
			sda_oe = sel && rd && !DATA[7 - cnt];
	end
endmodule
`default_nettype wire

/* tb/tb_ims_ctrl.sv */
// self-checking bench: register access over avalon-mm, master walk to a target
// assumes open-drain wires with pull-ups, one 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_ims_ctrl;
	logic        i_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_wdata = 32'h0;
	logic        cpu_idle = 1'b0;
	logic [31:0] avs_rdata;
	logic        avs_wait;
	logic        scl_oe;
	logic        sda_oe;
	logic        peer_oe;
	logic        pins_owned;
	logic [31:0] q;
	int          n_mismatch = 0;
	int          comparisons = 0;
	wire  logic  scl;
	wire  logic  sda;
	assign scl = !scl_oe;
	assign sda = !(sda_oe | peer_oe);
	always #10 i_clk = !i_clk;
	ims_ctrl dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_wdata),
		.o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait), .i_cpu_idle(cpu_idle),
		.i_scl(scl), .i_sda(sda), .o_scl_o(), .o_scl_oe(scl_oe), .o_sda_o(), .o_sda_oe(sda_oe),
		.o_pins_owned(pins_owned));
	ims_peer peer_u (.scl(scl), .sda(sda), .sda_oe(peer_oe));
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// hold the request until waitrequest is sampled low
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_wdata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge i_clk);
			n++;
		end while (avs_wait !== 1'b0 && n < 40);
		q = avs_rdata;
		if (n >= 40)
			chk("waitrequest", 32'h1, 32'h0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic poll(input logic [4:0] a, input logic [31:0] m);
		int n;
		n = 0;
		do begin
			acc(1'b0, a, 32'h0);
			n++;
		end while ((q & m) != 32'h0 && n < 1000);
		chk("go bits", q & m, 32'h0);
	endtask
	task automatic go(input logic [31:0] c, input logic [31:0] m);
		acc(1'b1, ims_pkg::OFS_CTRL, c);
		poll(ims_pkg::OFS_CTRL, m);
	endtask
	task automatic tx(input logic [7:0] b, input logic nk);
		acc(1'b1, ims_pkg::OFS_TXD, {24'h0, b});
		poll(ims_pkg::OFS_STAT, 32'h1);
		chk("nack_seen", {31'h0, q[1]}, {31'h0, nk});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		acc(1'b0, ims_pkg::OFS_CTRL, 32'h0);
		chk("bus_control", q, 32'h1000);
		acc(1'b0, ims_pkg::OFS_RATE, 32'h0);
		chk("rate_reload", q, 32'(ims_pkg::CLK_HZ / 100_000 - ims_pkg::CLK_HZ / 10_000_000 - 1));
		acc(1'b0, 5'h1C, 32'h0);
		chk("unmapped", q, 32'h0);
		acc(1'b1, ims_pkg::OFS_CTRL, 32'h4000);
		acc(1'b0, ims_pkg::OFS_CTRL, 32'h0);
		chk("release kept", q, 32'h1000);
		acc(1'b1, ims_pkg::OFS_CTRL, 32'h1040);
		acc(1'b1, ims_pkg::OFS_CTRL, 32'h0040);
		acc(1'b0, ims_pkg::OFS_CTRL, 32'h0);
		chk("release cleared", q, 32'h0040);
		acc(1'b1, ims_pkg::OFS_RATE, 32'h2);
		cpu_idle <= 1'b1;
		acc(1'b1, ims_pkg::OFS_CTRL, 32'hB001);
		repeat (40) @(posedge i_clk);
		acc(1'b0, ims_pkg::OFS_CTRL, 32'h0);
		chk("halted start_go", q, 32'hB001);
		cpu_idle <= 1'b0;
		poll(ims_pkg::OFS_CTRL, 32'h1);
		chk("pins_owned", {31'h0, pins_owned}, 32'h1);
		acc(1'b1, ims_pkg::OFS_RATE, 32'(ims_pkg::RATE_FAST));
		tx(8'hA2, 1'b1);
		acc(1'b1, ims_pkg::OFS_RATE, 32'h2);
		go(32'h9002, 32'h2);
		tx(8'hA0, 1'b0);
		tx(8'h12, 1'b0);
		go(32'h9002, 32'h2);
		tx(8'hA1, 1'b0);
		go(32'h9008, 32'h8);
		acc(1'b0, ims_pkg::OFS_RXD, 32'h0);
		chk("received byte", q, 32'hA5);
		go(32'h9030, 32'h10);
		go(32'h9004, 32'h4);
		acc(1'b0, ims_pkg::OFS_STAT, 32'h0);
		chk("bus_owner", {31'h0, q[8]}, 32'h0);
		acc(1'b1, ims_pkg::OFS_CTRL, 32'h1000);
		repeat (2) @(posedge i_clk);
		chk("pins_owned", {31'h0, pins_owned}, 32'h0);
		end_sim();
	end
	initial begin
		#400_000;
		chk("watchdog", 32'h1, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
